// *** verification/ebt_pwm_partner.sv ***
`default_nettype none
module ebt_pwm_partner (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_base,
  output logic [15:0] o_gap,
  output logic [15:0] o_pulses
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] cnt_ff;
  // ---------------------------------------------------------------
  // pwm time base consumer
  // ---------------------------------------------------------------
  // only the spacing of base pulses matters to a pwm period
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff <= 16'h0000;
      o_gap <= 16'h0000;
      o_pulses <= 16'h0000;
    end else if (i_base) begin
      o_gap <= cnt_ff + 16'h0001;
      o_pulses <= o_pulses + 16'h0001;
      cnt_ff <= 16'h0000;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// *** verification/tb_eight_bit_period_timer.sv ***
`default_nettype none
module tb_eight_bit_period_timer;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk, i_rst_n, i_wr, i_rd;
  logic [11:0] i_addr;
  logic [7:0] i_wdata, o_rdata, v;
  logic [2:0] o_irq, o_match_pulse;
  logic [15:0] gap, pulses, base;
  int bad_count = 0;
  int checked = 0;

  ebt_timer_top dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_match_pulse(o_match_pulse));
  ebt_pwm_partner pwm (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_base(o_match_pulse[0]),
    .o_gap(gap), .o_pulses(pulses));

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  // ---------------------------------------------------------------
  // bus and compare helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  // write followed by a read of the same register with no gap
  task automatic wr_rd(input logic [11:0] a, input logic [7:0] dat, output logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= dat;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic wait_pulses(input int n);
    int i = 0;
    logic [15:0] s;
    s = pulses;
    while (int'(pulses - s) < n && i < 2000) begin
      @(posedge i_clk);
      i++;
    end
    chk(16'(i < 2000), 16'h0001);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 3; i++) begin
      rd(ebt_pkg::CON_ADDR[i], v);
      chk(16'(v), 16'h0000);
      rd(ebt_pkg::CNT_ADDR[i], v);
      chk(16'(v), 16'h0000);
      rd(ebt_pkg::PER_ADDR[i], v);
      chk(16'(v), 16'h00ff);
    end
    rd(ebt_pkg::FLAG_ADDR, v);
    chk(16'(v), 16'h0000);
    rd(ebt_pkg::IEN_ADDR, v);
    chk(16'(v), 16'h0000);
  endtask
  task automatic t_regs;
    for (int i = 0; i < 3; i++) begin
      wr_rd(ebt_pkg::PER_ADDR[i], 8'h5a, v);
      chk(16'(v), 16'h005a);
      wr(ebt_pkg::CNT_ADDR[i], 8'ha5);
      rd(ebt_pkg::CNT_ADDR[i], v);
      chk(16'(v), 16'h00a5);
      wr(ebt_pkg::CON_ADDR[i], 8'h80);
      rd(ebt_pkg::CON_ADDR[i], v);
      chk(16'(v), 16'h0000);
    end
    rd(12'h000, v);
    chk(16'(v), 16'h0000);
  endtask
  task automatic t_prescale;
    for (int s = 0; s < 4; s++) begin
      wr(ebt_pkg::CON_ADDR[0], 8'h00);
      wr(ebt_pkg::CNT_ADDR[0], 8'h00);
      wr(ebt_pkg::PER_ADDR[0], 8'h02);
      wr(ebt_pkg::CON_ADDR[0], 8'h04 | 8'(s));
      wait_pulses(2);
      chk(gap, (s == 0) ? 16'd3 : (s == 1) ? 16'd12 : 16'd48);
    end
  endtask
  task automatic t_post;
    int i = 0;
    wr(ebt_pkg::CON_ADDR[0], 8'h00);
    wr(ebt_pkg::CNT_ADDR[0], 8'h00);
    wr(ebt_pkg::PER_ADDR[0], 8'h01);
    wr(ebt_pkg::FLAG_ADDR, 8'h00);
    wr(ebt_pkg::IEN_ADDR, 8'h01);
    base = pulses;
    wr(ebt_pkg::CON_ADDR[0], 8'h1c);
    while (o_irq[0] !== 1'b1 && i < 200) begin
      @(posedge i_clk);
      i++;
    end
    chk(pulses - base, 16'd4);
    wr(ebt_pkg::IEN_ADDR, 8'h00);
    rd(ebt_pkg::FLAG_ADDR, v);
    chk(16'(v[0]), 16'h0001);
    chk(16'(o_irq), 16'h0000);
    wr(ebt_pkg::CON_ADDR[0], 8'h00);
    wr(ebt_pkg::FLAG_ADDR, 8'h00);
    rd(ebt_pkg::FLAG_ADDR, v);
    chk(16'(v), 16'h0000);
  endtask
  task automatic t_chans;
    int n;
    wr(ebt_pkg::FLAG_ADDR, 8'h00);
    wr(ebt_pkg::IEN_ADDR, 8'h06);
    for (int i = 1; i < 3; i++) begin
      n = 0;
      wr(ebt_pkg::PER_ADDR[i], 8'h01);
      wr(ebt_pkg::CNT_ADDR[i], 8'h00);
      wr(ebt_pkg::CON_ADDR[i], 8'h04);
      repeat (8) begin
        @(posedge i_clk);
        #1 n += int'(o_match_pulse[i]);
      end
      wr(ebt_pkg::CON_ADDR[i], 8'h00);
      chk(16'(n), 16'd4);
      chk(16'(o_irq[i]), 16'h0001);
    end
  endtask
  task automatic t_hold;
    wr(ebt_pkg::CNT_ADDR[0], 8'h07);
    repeat (20) @(posedge i_clk);
    rd(ebt_pkg::CNT_ADDR[0], v);
    chk(16'(v), 16'h0007);
    // divide by 16 leaves time to read before the first tick
    wr(ebt_pkg::CON_ADDR[0], 8'h06);
    rd(ebt_pkg::CNT_ADDR[0], v);
    chk(16'(v), 16'h0007);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #3000000;
    bad_count++;
    print_verdict();
  end
  initial begin
    i_rst_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 12'h000;
    i_wdata = 8'h00;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_prescale();
    t_post();
    t_chans();
    t_hold();
    // reset in mid-run must restore periods, counts, flags and enables
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reset();
    print_verdict();
  end
endmodule
`default_nettype wire

// *** verilog/ebt_chan.sv ***
`default_nettype none
module ebt_chan (
  input wire logic i_clk,
  input wire logic i_rst_n,
  ebt_chan_if.tmr bus
);
  logic [3:0] pre_ff;
  logic [3:0] post_ff;
  logic [7:0] cnt_ff;
  logic match_ff;
  logic done_ff;
  logic [3:0] nxt_pre;
  logic [3:0] nxt_post;
  logic [7:0] nxt_cnt;
  logic nxt_match;
  logic nxt_done;
  logic tick;

  // ---------------------------------------------------------------
  // prescaler, count, postscaler
  // ---------------------------------------------------------------
  always_comb begin
    // a count or control write cancels this cycle's tick
    tick = bus.on && !bus.cnt_we && !bus.con_we &&
           (pre_ff == ebt_pkg::pre_last(bus.ckps));
    nxt_pre = pre_ff;
    nxt_post = post_ff;
    nxt_cnt = cnt_ff;
    nxt_match = 1'b0;
    nxt_done = 1'b0;
    if (bus.on) begin
      nxt_pre = tick ? 4'h0 : pre_ff + 4'h1;
    end
    if (tick) begin
      if (cnt_ff == bus.period) begin
        nxt_cnt = 8'h00;
        nxt_match = 1'b1;
        if (post_ff == bus.outps) begin
          nxt_done = 1'b1;
          nxt_post = 4'h0;
        end else begin
          nxt_post = post_ff + 4'h1;
        end
      end else begin
        nxt_cnt = cnt_ff + 8'h01;
      end
    end
    if (bus.cnt_we || bus.con_we) begin
      nxt_pre = 4'h0;
      nxt_post = 4'h0;
    end
    if (bus.cnt_we) begin
      nxt_cnt = bus.wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_ff <= 4'h0;
      post_ff <= 4'h0;
      cnt_ff <= ebt_pkg::CNT_RST;
      match_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      pre_ff <= nxt_pre;
      post_ff <= nxt_post;
      cnt_ff <= nxt_cnt;
      match_ff <= nxt_match;
      done_ff <= nxt_done;
    end
  end

  assign bus.count = cnt_ff;
  assign bus.match = match_ff;
  assign bus.done = done_ff;
endmodule
`default_nettype wire

// *** verilog/ebt_chan_if.sv ***
`default_nettype none
interface ebt_chan_if;
  logic on;
  logic [1:0] ckps;
  logic [3:0] outps;
  logic [7:0] period;
  logic cnt_we;
  logic con_we;
  logic [7:0] wdata;
  logic [7:0] count;
  logic match;
  logic done;
  modport ctl (output on, ckps, outps, period, cnt_we, con_we, wdata, input count, match, done);
  modport tmr (input on, ckps, outps, period, cnt_we, con_we, wdata, output count, match, done);
endinterface
`default_nettype wire

// *** verilog/ebt_pkg.sv ***
`default_nettype none
package ebt_pkg;
  // ---------------------------------------------------------------
  // register map, index 0 = timer a1, 1 = timer a2, 2 = timer b
  // ---------------------------------------------------------------
  localparam int N_TMR = 3;
  localparam int AW = 12;
  localparam logic [2:0][11:0] CON_ADDR = {12'hf1b, 12'hf1e, 12'hf76};
  localparam logic [2:0][11:0] CNT_ADDR = {12'hf1c, 12'hf1f, 12'hf77};
  localparam logic [2:0][11:0] PER_ADDR = {12'hf1d, 12'hf20, 12'hf78};
  localparam logic [11:0] FLAG_ADDR = 12'hf80;
  localparam logic [11:0] IEN_ADDR = 12'hf81;
  // ---------------------------------------------------------------
  // control fields and reset values
  // ---------------------------------------------------------------
  localparam int CKPS_LSB = 0;
  localparam int ON_BIT = 2;
  localparam int OUTPS_LSB = 3;
  localparam logic [7:0] CON_MASK = 8'h7f;
  localparam logic [7:0] CON_RST = 8'h00;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] PER_RST = 8'hff;
  localparam logic [2:0] FLAG_RST = 3'h0;
  localparam logic [2:0] IEN_RST = 3'h0;
  // ---------------------------------------------------------------
  // prescaler terminal counts
  // ---------------------------------------------------------------
  localparam logic [3:0] PRE_LAST_DIV1 = 4'h0;
  localparam logic [3:0] PRE_LAST_DIV4 = 4'h3;
  localparam logic [3:0] PRE_LAST_DIV16 = 4'hf;

  function automatic logic [3:0] pre_last(input logic [1:0] sel);
    if (sel == 2'h0) begin
      return PRE_LAST_DIV1;
    end else if (sel == 2'h1) begin
      return PRE_LAST_DIV4;
    end else begin
      return PRE_LAST_DIV16;
    end
  endfunction
endpackage
`default_nettype wire

// *** verilog/ebt_timer_top.sv ***
// Overview of operation
// - each timer has readable, writable 8-bit count and period registers
// - timer counts only while control bit 2 is set
// - prescale select 00 divides by 1, 01 by 4, 1x by 16
// - postscale select 0000..1111 gives ratios 1:1 to 1:16
// - finished postscale sets match flag, held until software clears it
// - interrupt request only while the flag's enable bit is set
// - count rises from 00h to period, then returns to 00h
// - reset loads period registers with FFh
// - reset clears count registers
// - count write, control write or reset clears prescaler and postscaler
// - control write leaves the count unchanged
// - pre-postscaler match pulse only serves as pwm time base
// - control bit 7 reads zero, ignores writes; others reset to zero
// - each wrap to 00h gives one rising pulse on a match signal, except period 00h at divide by 1
`default_nettype none
module ebt_timer_top (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [11:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic [2:0] o_irq,
  output logic [2:0] o_match_pulse
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [2:0][7:0] con_ff;
  logic [2:0][7:0] per_ff;
  logic [2:0] flag_ff;
  logic [2:0] ien_ff;
  logic [7:0] rdata_ff;
  logic [2:0][7:0] nxt_con;
  logic [2:0][7:0] nxt_per;
  logic [2:0] nxt_flag;
  logic [2:0] nxt_ien;
  logic [7:0] nxt_rdata;
  logic [2:0][7:0] cnt_w;
  logic [2:0] match_w;
  logic [2:0] done_w;
  logic [2:0] cnt_we;
  logic [2:0] con_we;

  // ---------------------------------------------------------------
  // timer channels
  // ---------------------------------------------------------------
  for (genvar g = 0; g < ebt_pkg::N_TMR; g++) begin : g_tmr
    ebt_chan_if ch_if ();
    assign cnt_we[g] = i_wr && (i_addr == ebt_pkg::CNT_ADDR[g]);
    assign con_we[g] = i_wr && (i_addr == ebt_pkg::CON_ADDR[g]);
    assign ch_if.on = con_ff[g][ebt_pkg::ON_BIT];
    assign ch_if.ckps = con_ff[g][ebt_pkg::CKPS_LSB +: 2];
    assign ch_if.outps = con_ff[g][ebt_pkg::OUTPS_LSB +: 4];
    assign ch_if.period = per_ff[g];
    assign ch_if.cnt_we = cnt_we[g];
    assign ch_if.con_we = con_we[g];
    assign ch_if.wdata = i_wdata;
    assign cnt_w[g] = ch_if.count;
    assign match_w[g] = ch_if.match;
    assign done_w[g] = ch_if.done;
    ebt_chan u_chan (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .bus(ch_if.tmr)
    );
  end

  // ---------------------------------------------------------------
  // register writes and read mux
  // ---------------------------------------------------------------
  always_comb begin
    nxt_con = con_ff;
    nxt_per = per_ff;
    nxt_ien = ien_ff;
    nxt_flag = flag_ff;
    nxt_rdata = 8'h00;
    for (int i = 0; i < ebt_pkg::N_TMR; i++) begin
      if (con_we[i]) begin
        nxt_con[i] = i_wdata & ebt_pkg::CON_MASK;
      end
      if (i_wr && (i_addr == ebt_pkg::PER_ADDR[i])) begin
        nxt_per[i] = i_wdata;
      end
    end
    if (i_wr && (i_addr == ebt_pkg::FLAG_ADDR)) begin
      nxt_flag = i_wdata[2:0];
    end
    if (i_wr && (i_addr == ebt_pkg::IEN_ADDR)) begin
      nxt_ien = i_wdata[2:0];
    end
    // a set in the clearing cycle wins, so no event is lost
    nxt_flag = nxt_flag | done_w;
    if (i_rd) begin
      for (int i = 0; i < ebt_pkg::N_TMR; i++) begin
        if (i_addr == ebt_pkg::CON_ADDR[i]) begin
          nxt_rdata = con_ff[i];
        end else if (i_addr == ebt_pkg::CNT_ADDR[i]) begin
          nxt_rdata = cnt_w[i];
        end else if (i_addr == ebt_pkg::PER_ADDR[i]) begin
          nxt_rdata = per_ff[i];
        end
      end
      if (i_addr == ebt_pkg::FLAG_ADDR) begin
        nxt_rdata = {5'h00, flag_ff};
      end else if (i_addr == ebt_pkg::IEN_ADDR) begin
        nxt_rdata = {5'h00, ien_ff};
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      con_ff <= {3{ebt_pkg::CON_RST}};
      per_ff <= {3{ebt_pkg::PER_RST}};
      flag_ff <= ebt_pkg::FLAG_RST;
      ien_ff <= ebt_pkg::IEN_RST;
      rdata_ff <= 8'h00;
    end else begin
      con_ff <= nxt_con;
      per_ff <= nxt_per;
      flag_ff <= nxt_flag;
      ien_ff <= nxt_ien;
      rdata_ff <= nxt_rdata;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_rdata = rdata_ff;
  // gated late so software can still poll a masked flag
  assign o_irq = flag_ff & ien_ff;
  // wrap pulse serves only as pwm time base; no baud clock tap exists
  assign o_match_pulse = match_w;

  // ---------------------------------------------------------------
  // checks on timer a1
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  logic wr_con0;
  logic wr_cnt0;
  logic wr_per0;
  logic wr_flag;
  assign wr_con0 = i_wr && (i_addr == ebt_pkg::CON_ADDR[0]);
  assign wr_cnt0 = i_wr && (i_addr == ebt_pkg::CNT_ADDR[0]);
  assign wr_per0 = i_wr && (i_addr == ebt_pkg::PER_ADDR[0]);
  assign wr_flag = i_wr && (i_addr == ebt_pkg::FLAG_ADDR);

  con_bit7_zero_a: assert property (
    i_rd && (i_addr == ebt_pkg::CON_ADDR[0]) |=> (o_rdata[7] == 1'b0) && (o_rdata[6:0] == con_ff[0][6:0]))
    else $error("control bit 7 read back nonzero");

  per_write_a: assert property (
    wr_per0 ##1 i_rd && (i_addr == ebt_pkg::PER_ADDR[0]) && !wr_per0 |=> o_rdata == $past(i_wdata, 2))
    else $error("period register read differs from write");

  cnt_write_a: assert property (
    wr_cnt0 |=> cnt_w[0] == $past(i_wdata))
    else $error("count write not taken");

  off_hold_a: assert property (
    !con_ff[0][ebt_pkg::ON_BIT] && !wr_cnt0 |=> $stable(cnt_w[0]) && !match_w[0])
    else $error("timer moved while off");

  con_keep_cnt_a: assert property (
    wr_con0 && !wr_cnt0 |=> cnt_w[0] == $past(cnt_w[0]))
    else $error("control write changed count");

  wrap_zero_a: assert property (
    $rose(match_w[0]) |-> cnt_w[0] == 8'h00 && $past(cnt_w[0]) == $past(per_ff[0]))
    else $error("wrap not from period to zero");

  // period zero wraps every tick, so the pulse may legally stay high
  match_pulse_a: assert property (
    match_w[0] && (per_ff[0] != 8'h00) |=> !match_w[0])
    else $error("match pulse longer than one cycle");

  div1_rate_a: assert property (
    con_ff[0][ebt_pkg::ON_BIT] && con_ff[0][1:0] == 2'h0 && cnt_w[0] != per_ff[0]
    && !wr_cnt0 && !wr_con0 && $stable(con_ff[0]) |=> cnt_w[0] == $past(cnt_w[0]) + 8'h01)
    else $error("divide by one did not step each cycle");

  flag_set_a: assert property (
    done_w[0] |=> flag_ff[0])
    else $error("postscaler event lost");

  flag_hold_a: assert property (
    flag_ff[0] && !wr_flag |=> flag_ff[0])
    else $error("flag dropped without software clear");

  irq_mask_a: assert property (
    !ien_ff[0] |-> !o_irq[0])
    else $error("masked flag reached irq");

  post_one_a: assert property (
    con_ff[0][ebt_pkg::OUTPS_LSB +: 4] == 4'h0 && $stable(con_ff[0]) && match_w[0] |-> done_w[0])
    else $error("1:1 postscale missed a match");

  wrap_cov_c: cover property (match_w[0] ##1 !match_w[0]);
  flag_cov_c: cover property (done_w[0] ##2 o_irq[0]);
  clr_race_c: cover property (wr_flag && done_w[0]);
endmodule
`default_nettype wire
